/* rtl/obl_loader.sv */
`timescale 1ns/100ps
`default_nettype none
module obl_loader
	import obl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sysResetReq,
	input  wire logic        extResetReq,
	input  wire logic        stopRecoveryReq,
	output logic             flashRdEn,
	output logic [15:0]      flashAddr,
	input  wire logic [7:0]  flashRdData,
	input  wire logic        flashRdValid,
	output logic             cpuHoldReset,
	output obl_cfg_t         optCfg,
	output obl_ctl_t         optCtl,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	obl_state_t  state_q, state_d;
	obl_cfg_t    cfg_q,   cfg_d;
	obl_ctl_t    ctl_q,   ctl_d;
	logic        hold_q,  hold_d;
	logic        rsvdBad_q, rsvdBad_d;
	logic [7:0]  loadCnt_q, loadCnt_d;
	logic        swRst_q, swRst_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic        fetchStart;
	logic        fetchDone;
	logic [7:0]  userByte;
	logic [7:0]  rsvdByte;

	obl_fetch u_fetch (
		.clk         (clk),
		.rst_n       (rst_n),
		.start       (fetchStart),
		.flashRdEn   (flashRdEn),
		.flashAddr   (flashAddr),
		.flashRdData (flashRdData),
		.flashRdValid(flashRdValid),
		.userByte    (userByte),
		.rsvdByte    (rsvdByte),
		.done        (fetchDone)
	);

	// any reset kind, including software request, restarts the load
	wire anyReset = sysResetReq | extResetReq | stopRecoveryReq | swRst_q;

	always_comb begin
		state_d    = state_q;
		fetchStart = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				fetchStart = 1'b1;
				state_d    = ST_FETCH;
			end
			ST_FETCH: begin
				if (anyReset) begin
					state_d = ST_IDLE;
				end else if (fetchDone) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (anyReset) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// latches change only at the end of a load
	wire loadEnd = (state_q == ST_FETCH) & fetchDone & ~anyReset;
	wire obl_cfg_t newCfg = obl_decode(userByte);

	assign cfg_d = loadEnd ? newCfg : cfg_q;
	assign hold_d = ~(loadEnd | ((state_q == ST_RUN) & ~anyReset));
	assign rsvdBad_d = loadEnd ? ((rsvdByte != ERASED_BYTE) |
		~userByte[BIT_RSVD]) : rsvdBad_q;
	assign loadCnt_d = loadEnd ? loadCnt_q + 8'h01 : loadCnt_q;

	always_comb begin
		ctl_d = ctl_q;
		if (loadEnd) begin
			ctl_d.wdtTimeoutIrq        = ~newCfg.watchdog_timeout_reset_select;
			ctl_d.wdtTimeoutShortReset = newCfg.watchdog_timeout_reset_select;
			ctl_d.wdtStartAtPowerUp    = ~newCfg.watchdog_always_on;
			ctl_d.brownoutOffInStop    = ~newCfg.brownout_always_on;
			ctl_d.codeReadBlocked      = ~newCfg.read_protect;
			ctl_d.debugLimited         = ~newCfg.read_protect;
			ctl_d.userFlashWriteEn     = newCfg.flash_write_protect;
			ctl_d.debugMassEraseEn     = 1'b1;
		end
	end

	// apb slave: one wait-free access phase; latches are not mapped
	wire apbSetup  = psel & ~penable;
	wire apbAccess = psel & penable & pready_q;
	wire hitCtrl   = (paddr == REG_CTRL);
	wire hitStatus = (paddr == REG_STATUS);
	wire hitAny    = hitCtrl | hitStatus;

	wire [31:0] statusWord = {16'h0000, loadCnt_q, 6'h00, rsvdBad_q,
		~hold_q};

	assign pready_d  = apbSetup;
	assign pslverr_d = apbSetup & ~hitAny;
	assign prdata_d  = (apbSetup & ~pwrite & hitStatus) ? statusWord :
		32'h0000_0000;
	assign swRst_d   = apbAccess & pwrite & hitCtrl & pwdata[CTRL_SWRST];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q   <= ST_IDLE;
			cfg_q     <= CFG_RESET;
			ctl_q     <= CTL_RESET;
			hold_q    <= 1'b1;
			rsvdBad_q <= 1'b0;
			loadCnt_q <= LOAD_CNT_RESET;
			swRst_q   <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			cfg_q     <= cfg_d;
			ctl_q     <= ctl_d;
			hold_q    <= hold_d;
			rsvdBad_q <= rsvdBad_d;
			loadCnt_q <= loadCnt_d;
			swRst_q   <= swRst_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign cpuHoldReset = hold_q;
	assign optCfg       = cfg_q;
	assign optCtl       = ctl_q;
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
endmodule : obl_loader
`default_nettype wire

/* rtl/obl_pkg.sv */
`default_nettype none
package obl_pkg;
	localparam logic [15:0] USER_OPT_ADDR = 16'h0000;
	localparam logic [15:0] RSVD_OPT_ADDR = 16'h0001;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam int BIT_WD_RESP  = 7;
	localparam int BIT_WD_ON    = 6;
	localparam int BIT_OSC_HI   = 5;
	localparam int BIT_OSC_LO   = 4;
	localparam int BIT_BO_ON    = 3;
	localparam int BIT_RD_PROT  = 2;
	localparam int BIT_RSVD     = 1;
	localparam int BIT_WR_PROT  = 0;
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam int CTRL_SWRST   = 0;
	localparam int STAT_DONE    = 0;
	localparam int STAT_RSVDBAD = 1;
	localparam int STAT_CNT_LO  = 8;
	localparam logic [7:0] LOAD_CNT_RESET = 8'h00;

	typedef enum logic [1:0] {
		OSC_EXT_RC  = 2'b00,
		OSC_MIN_PWR = 2'b01,
		OSC_MED_PWR = 2'b10,
		OSC_MAX_PWR = 2'b11
	} obl_osc_t;

	typedef struct packed {
		logic     watchdog_timeout_reset_select;
		logic     watchdog_always_on;
		obl_osc_t oscillator_drive_select;
		logic     brownout_always_on;
		logic     read_protect;
		logic     flash_write_protect;
	} obl_cfg_t;

	typedef struct packed {
		logic wdtTimeoutIrq;
		logic wdtTimeoutShortReset;
		logic wdtStartAtPowerUp;
		logic brownoutOffInStop;
		logic codeReadBlocked;
		logic debugLimited;
		logic userFlashWriteEn;
		logic debugMassEraseEn;
	} obl_ctl_t;

	localparam obl_cfg_t CFG_RESET = '{1'b1, 1'b1, OSC_MAX_PWR, 1'b1,
		1'b1, 1'b1};
	// decoded controls that match the erased defaults
	localparam obl_ctl_t CTL_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b1, 1'b1};

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_RUN   = 2'b10
	} obl_state_t;

	function automatic obl_cfg_t obl_decode(input logic [7:0] b);
		obl_cfg_t c;
		c.watchdog_timeout_reset_select = b[BIT_WD_RESP];
		c.watchdog_always_on            = b[BIT_WD_ON];
		c.oscillator_drive_select       = obl_osc_t'(b[BIT_OSC_HI:BIT_OSC_LO]);
		c.brownout_always_on            = b[BIT_BO_ON];
		c.read_protect                  = b[BIT_RD_PROT];
		c.flash_write_protect           = b[BIT_WR_PROT];
		return c;
	endfunction : obl_decode
endpackage : obl_pkg
`default_nettype wire

/* rtl/obl_fetch.sv */
`timescale 1ns/100ps
`default_nettype none
// reads the two option bytes in turn; flash is only ever read here
module obl_fetch
	import obl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	output logic             flashRdEn,
	output logic [15:0]      flashAddr,
	input  wire logic [7:0]  flashRdData,
	input  wire logic        flashRdValid,
	output logic [7:0]       userByte,
	output logic [7:0]       rsvdByte,
	output logic             done
);
	logic        busy_q,  busy_d;
	logic        second_q, second_d;
	logic [7:0]  user_q,  user_d;
	logic [7:0]  rsvd_q,  rsvd_d;
	logic        done_q,  done_d;
	logic        fresh_q;

	// an answer just after a restart belongs to a read from before it
	wire takeUser = busy_q & flashRdValid & ~second_q & ~fresh_q;
	wire takeRsvd = busy_q & flashRdValid & second_q & ~fresh_q;

	assign busy_d   = start | (busy_q & ~takeRsvd);
	assign second_d = start ? 1'b0 : (second_q | takeUser);
	assign user_d   = takeUser ? flashRdData : user_q;
	assign rsvd_d   = takeRsvd ? flashRdData : rsvd_q;
	assign done_d   = takeRsvd & ~start;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_q   <= 1'b0;
			second_q <= 1'b0;
			user_q   <= ERASED_BYTE;
			rsvd_q   <= ERASED_BYTE;
			done_q   <= 1'b0;
			fresh_q  <= 1'b0;
		end else begin
			busy_q   <= busy_d;
			second_q <= second_d;
			user_q   <= user_d;
			rsvd_q   <= rsvd_d;
			done_q   <= done_d;
			fresh_q  <= start;
		end
	end

	assign flashRdEn = busy_q;
	assign flashAddr = second_q ? RSVD_OPT_ADDR : USER_OPT_ADDR;
	assign userByte  = user_q;
	assign rsvdByte  = rsvd_q;
	assign done      = done_q;
endmodule : obl_fetch
`default_nettype wire

/* tb/obl_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
module obl_flash_model (
	input  wire logic        clk,
	input  wire logic        flashRdEn,
	input  wire logic [15:0] flashAddr,
	input  wire logic [7:0]  b0,
	input  wire logic [7:0]  b1,
	input  wire logic [2:0]  lat,
	output logic [7:0]       flashRdData,
	output logic             flashRdValid
);
	logic [2:0] waitQ = 3'h0;
	wire        hit = flashRdEn && !flashRdValid && waitQ >= lat;
	// read only: no path alters the stored bytes
	always @(posedge clk) begin
		waitQ <= flashRdEn && !flashRdValid ? waitQ + 3'h1 : 3'h0;
		flashRdValid <= hit;
		flashRdData <= hit ? (flashAddr[0] ? b1 : b0) : ~flashRdData;
	end
endmodule : obl_flash_model
`default_nettype wire

/* tb/obl_loader_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module obl_loader_properties
	import obl_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        sysResetReq,
	input wire logic        extResetReq,
	input wire logic        stopRecoveryReq,
	input wire logic        flashRdEn,
	input wire logic [15:0] flashAddr,
	input wire logic [7:0]  flashRdData,
	input wire logic        flashRdValid,
	input wire logic        cpuHoldReset,
	input wire obl_cfg_t    optCfg,
	input wire obl_ctl_t    optCtl,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic [7:0] byteQ;
	wire        anyReq = sysResetReq || extResetReq || stopRecoveryReq;
	wire        rdHit = flashRdEn && flashRdValid;
	wire        lastRd = rdHit && flashAddr == 16'h0001;
	wire        setup = psel && !penable;
	wire [7:0]  ctlExp = {~optCfg[6], optCfg[6], ~optCfg[5], ~optCfg[2],
		~optCfg[1], ~optCfg[1], optCfg[0], 1'b1};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk)
		if (rdHit && flashAddr == 16'h0000)
			byteQ <= flashRdData;
	a_hold_till_done: assert property ($fell(cpuHoldReset) |->
		$past(lastRd, 2)) else $error("early release");
	a_cfg_loaded: assert property ($fell(cpuHoldReset) |->
		optCfg == {byteQ[7:2], byteQ[0]}) else $error("bad load");
	a_cfg_held: assert property (!cpuHoldReset &&
		!$fell(cpuHoldReset) |-> $stable(optCfg)) else $error("cfg moved");
	a_req_holds: assert property (anyReq |=> cpuHoldReset)
		else $error("no hold");
	a_req_reload: assert property (anyReq ##1 !anyReq |->
		##[1:4] (flashRdEn && flashAddr == 16'h0000)) else $error("no reload");
	a_ctl_decode: assert property (optCtl == ctlExp)
		else $error("bad decode");
	a_apb_ready: assert property (setup |=> pready)
		else $error("no ready");
	a_unmapped_err: assert property (setup && paddr != REG_CTRL &&
		paddr != REG_STATUS |=> pslverr) else $error("no error");
	cover property ($fell(cpuHoldReset));
	cover property (anyReq && flashRdEn);
	cover property (setup ##1 pslverr);
endmodule : obl_loader_properties
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin badCount++; \
	$display("Error at %0t: %h vs %h", $time, a, e); end end
module tb
	import obl_pkg::*;
;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, sysResetReq = 1'b0, extResetReq = 1'b0;
	logic        stopRecoveryReq = 1'b0, flashRdEn, flashRdValid, err;
	logic        cpuHoldReset, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, rdExp;
	logic [15:0] flashAddr;
	logic [7:0]  flashRdData, b0 = 8'hff, b1 = 8'hff;
	logic [2:0]  lat = 3'h0;
	obl_cfg_t    optCfg;
	obl_ctl_t    optCtl;
	int          badCount = 0, nChecks = 0, cyc = 0, seed = 12679, i;

	always #25 clk = ~clk;
	always @(posedge clk) if (++cyc == 5000) end_of_test();
	obl_loader dut (.*);
	obl_flash_model flash (.*);

	function automatic logic [14:0] expOf(input logic [7:0] b);
		return {b[7:2], b[0], ~b[7], b[7], ~b[6], ~b[3], ~b[2], ~b[2],
			b[0], 1'b1};
	endfunction : expOf
	task automatic pulse(input int k);
		@(posedge clk);
		{sysResetReq, extResetReq, stopRecoveryReq} <= 3'(4 >> k);
		@(posedge clk);
		{sysResetReq, extResetReq, stopRecoveryReq} <= 3'h0;
	endtask : pulse
	task automatic waitLoad();
		i = 0;
		do @(negedge clk); while (cpuHoldReset !== 1'b0 && ++i < 80);
		`CHK({cpuHoldReset, optCfg, optCtl}, {1'b0, expOf(b0)})
	endtask : waitLoad
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do @(posedge clk); while (pready !== 1'b1);
		{err, rd} = {pslverr, prdata};
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic end_of_test();
		if (cyc >= 5000)
			badCount++;
		if (badCount == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		waitLoad();
		for (int k = 0; k < 12; k++) begin
			b0 = 8'($random(seed));
			b0[5:4] = 2'(k);
			b1 = k == 5 ? 8'h7e : 8'hff;
			lat = 3'(k % 7);
			pulse(k % 3);
			waitLoad();
			apb(1'b0, REG_STATUS, 32'($random(seed)));
			rdExp = {16'h0000, 8'(k + 2), 6'h00, b1 != 8'hff || !b0[1], 1'b1};
			`CHK({err, rd}, {1'b0, rdExp})
			b0 = ~b0;
			repeat (4) @(posedge clk);
			`CHK({optCfg, optCtl}, expOf(~b0))
			b0 = ~b0;
		end
		apb(1'b0, 12'h008, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		b0 = 8'h5a;
		apb(1'b1, REG_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		waitLoad();
		lat = 3'h6;
		b0 = 8'h21;
		pulse(0);
		repeat (4) @(posedge clk);
		pulse(2);
		waitLoad();
		end_of_test();
	end
endmodule : tb
bind obl_loader obl_loader_properties chk (.*);
`default_nettype wire
